// ### core/ddc_core.sv
/*
 * Dual DAC serial command core: a three-wire serial link carries 16-bit
 * command words that load channel input registers, update both DAC
 * registers together, and enter or leave sleep. Status over APB.
 * Assumes the link pins are asynchronous to clk and that the link clock
 * is slow enough (160 ns period here) to be sampled by the 4 ns clock.
 */
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module ddc_core
	import ddc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic chip_select_load,
	input wire logic serial_shift_clock,
	input wire logic serial_data_in,
	output logic [CODE_W-1:0] dac_a_out,
	output logic [CODE_W-1:0] dac_b_out,
	output logic outputs_hiz
);

	function automatic logic [31:0] pack2(input logic [CODE_W-1:0] lo,
		input logic [CODE_W-1:0] hi);
		logic [31:0] v;
		v = DATA_ZERO;
		v[CODE_W-1:0] = lo;
		v[HI_LSB +: CODE_W] = hi;
		return v;
	endfunction

	function automatic logic is_code(input logic [3:0] c,
		input logic [3:0] a, input logic [3:0] b, input logic [3:0] d);
		return (c == a) || (c == b) || (c == d);
	endfunction

	// Two-flop synchronisers plus a third stage for edge detection.
	logic cs_s1_r, cs_s2_r, cs_s3_r;
	logic sck_s1_r, sck_s2_r, sck_s3_r;
	logic sdi_s1_r, sdi_s2_r;
	logic [WORD_W-1:0] shift_r, shift_nxt;
	logic [WORD_W-1:0] last_r, last_nxt;
	logic [CODE_W-1:0] in_a_r, in_a_nxt, in_b_r, in_b_nxt;
	logic [CODE_W-1:0] dac_a_r, dac_a_nxt, dac_b_r, dac_b_nxt;
	logic sleep_r, sleep_nxt;
	logic link_en_r, link_en_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;

	wire sck_rise = sck_s2_r & ~sck_s3_r;
	wire cs_rise = cs_s2_r & ~cs_s3_r;
	wire shift_en = ~cs_s2_r & sck_rise & link_en_r;
	wire exec = cs_rise & link_en_r;
	wire [3:0] ctl = shift_r[CTL_LSB +: CTL_W];
	wire [CODE_W-1:0] code = shift_r[CODE_LSB +: CODE_W];
	wire ld_a = is_code(ctl, CC_LOAD_A, CC_UPD_A, CC_BOTH);
	wire ld_b = is_code(ctl, CC_LOAD_B, CC_UPD_B, CC_BOTH);
	wire upd = is_code(ctl, CC_UPDATE, CC_UPD_A, CC_UPD_B) ||
		(ctl == CC_BOTH);
	wire wake = upd || (ctl == CC_WAKE);
	wire go_sleep = ctl == CC_SLEEP;

	// Shift register moves only while selected; select high freezes it.
	assign shift_nxt = shift_en ? {shift_r[WORD_W-2:0], sdi_s2_r} :
		shift_r;
	assign last_nxt = exec ? shift_r : last_r;

	// Input registers load in wake or sleep; reserved codes match nothing.
	assign in_a_nxt = (exec && ld_a) ? code : in_a_r;
	assign in_b_nxt = (exec && ld_b) ? code : in_b_r;
	// Both DAC registers share one update term and see fresh input data.
	assign dac_a_nxt = (exec && upd) ? in_a_nxt : dac_a_r;
	assign dac_b_nxt = (exec && upd) ? in_b_nxt : dac_b_r;
	assign sleep_nxt = (exec && go_sleep) ? 1'b1 :
		(exec && wake) ? 1'b0 : sleep_r;

	// APB slave: read data is captured in the first access cycle, answered next; writes land in the answer cycle.
	wire access = psel & penable & ~pready_r;
	wire wr_done = psel & penable & pready_r & pwrite;
	wire hit_ctrl = paddr == OFS_CTRL;
	wire hit_st = paddr == OFS_STATUS;
	wire hit_in = paddr == OFS_INPUT;
	wire hit_dac = paddr == OFS_DAC;
	wire hit_last = paddr == OFS_LAST;
	wire mapped = hit_ctrl | hit_st | hit_in | hit_dac | hit_last;
	wire [31:0] ctrl_word = {31'h0000_0000, link_en_r};
	wire [31:0] st_word = {29'h0000_0000, link_en_r, cs_s2_r, sleep_r};
	wire [31:0] rd_word = hit_ctrl ? ctrl_word :
		hit_st ? st_word :
		hit_in ? pack2(in_a_r, in_b_r) :
		hit_dac ? pack2(dac_a_r, dac_b_r) :
		hit_last ? {16'h0000, last_r} : DATA_ZERO;

	assign pready_nxt = access;
	assign prdata_nxt = (access && !pwrite) ? rd_word : prdata_r;
	assign pslverr_nxt = access & ~mapped;
	assign link_en_nxt = (wr_done && hit_ctrl) ? pwdata[CTRL_EN_BIT] :
		link_en_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_s3_r <= 1'b1;
			sck_s1_r <= 1'b0;
			sck_s2_r <= 1'b0;
			sck_s3_r <= 1'b0;
			sdi_s1_r <= 1'b0;
			sdi_s2_r <= 1'b0;
		end else begin
			cs_s1_r <= chip_select_load;
			cs_s2_r <= cs_s1_r;
			cs_s3_r <= cs_s2_r;
			sck_s1_r <= serial_shift_clock;
			sck_s2_r <= sck_s1_r;
			sck_s3_r <= sck_s2_r;
			sdi_s1_r <= serial_data_in;
			sdi_s2_r <= sdi_s1_r;
		end
	end

	// Reset clears every code so both outputs start at zero scale.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_r <= WORD_RST;
			last_r <= WORD_RST;
			in_a_r <= CODE_RST;
			in_b_r <= CODE_RST;
			dac_a_r <= CODE_RST;
			dac_b_r <= CODE_RST;
			sleep_r <= 1'b0;
		end else begin
			shift_r <= shift_nxt;
			last_r <= last_nxt;
			in_a_r <= in_a_nxt;
			in_b_r <= in_b_nxt;
			dac_a_r <= dac_a_nxt;
			dac_b_r <= dac_b_nxt;
			sleep_r <= sleep_nxt;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			link_en_r <= CTRL_EN_RST;
			prdata_r <= DATA_ZERO;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			link_en_r <= link_en_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Outputs keep the DAC codes through sleep, so wake restores them.
	assign dac_a_out = dac_a_r;
	assign dac_b_out = dac_b_r;
	assign outputs_hiz = sleep_r;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_shift;
		shift_en |=> shift_r == {$past(shift_r[WORD_W-2:0]),
			$past(sdi_s2_r)};
	endproperty
	a_shift: assert property (p_shift)
		else $error("Shift register did not take the data bit.");

	property p_cs_high_hold;
		cs_s2_r ##1 cs_s2_r |-> $stable(shift_r);
	endproperty
	a_cs_high_hold: assert property (p_cs_high_hold)
		else $error("Shift register moved while select was high.");

	property p_pair_update;
		($changed(dac_a_r) || $changed(dac_b_r)) |->
			$past(exec) && $past(upd);
	endproperty
	a_pair_update: assert property (p_pair_update)
		else $error("DAC register changed without a joint update.");

	property p_nop;
		exec && (ctl == CC_NOP) |=> $stable(in_a_r) && $stable(in_b_r)
			&& $stable(dac_a_r) && $stable(dac_b_r) && $stable(sleep_r);
	endproperty
	a_nop: assert property (p_nop)
		else $error("No-operation code altered state.");

	property p_load_a;
		exec && (ctl == CC_LOAD_A) |=> in_a_r == $past(code) &&
			$stable(in_b_r) && $stable(dac_a_r) && $stable(sleep_r);
	endproperty
	a_load_a: assert property (p_load_a)
		else $error("Load A code misbehaved.");

	property p_load_b;
		exec && (ctl == CC_LOAD_B) |=> in_b_r == $past(code) &&
			$stable(in_a_r) && $stable(dac_b_r) && $stable(sleep_r);
	endproperty
	a_load_b: assert property (p_load_b)
		else $error("Load B code misbehaved.");

	property p_update;
		exec && (ctl == CC_UPDATE) |=> dac_a_r == $past(in_a_r) &&
			dac_b_r == $past(in_b_r) && !sleep_r;
	endproperty
	a_update: assert property (p_update)
		else $error("Update code did not copy inputs or wake.");

	property p_upd_a;
		exec && (ctl == CC_UPD_A) |=> dac_a_r == $past(code) &&
			dac_b_r == $past(in_b_r) && !sleep_r;
	endproperty
	a_upd_a: assert property (p_upd_a)
		else $error("Load A and update code misbehaved.");

	property p_upd_b;
		exec && (ctl == CC_UPD_B) |=> dac_b_r == $past(code) &&
			dac_a_r == $past(in_a_r) && !sleep_r;
	endproperty
	a_upd_b: assert property (p_upd_b)
		else $error("Load B and update code misbehaved.");

	property p_wake;
		exec && (ctl == CC_WAKE) |=> !outputs_hiz && $stable(dac_a_r)
			&& $stable(in_a_r);
	endproperty
	a_wake: assert property (p_wake)
		else $error("Wake code misbehaved.");

	property p_sleep;
		exec && (ctl == CC_SLEEP) |=> outputs_hiz && $stable(dac_a_r)
			&& $stable(dac_b_r) && $stable(in_a_r) && $stable(in_b_r);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("Sleep code misbehaved.");

	property p_both;
		exec && (ctl == CC_BOTH) |=> dac_a_r == $past(code) &&
			dac_b_r == $past(code) && in_a_r == dac_a_r && !sleep_r;
	endproperty
	a_both: assert property (p_both)
		else $error("Load both code misbehaved.");

	property p_sleep_load;
		sleep_r && exec && (ctl == CC_LOAD_A || ctl == CC_LOAD_B)
			|=> sleep_r;
	endproperty
	a_sleep_load: assert property (p_sleep_load)
		else $error("Input load woke the device.");

	property p_reserved;
		exec && !(upd || wake || go_sleep || ld_a || ld_b) |=>
			$stable(in_a_r) && $stable(in_b_r) && $stable(dac_a_r)
			&& $stable(dac_b_r) && $stable(sleep_r);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("Reserved code altered state.");

	property p_exec_edge;
		$rose(cs_s2_r) && link_en_r && (ctl == CC_SLEEP) |=> outputs_hiz;
	endproperty
	a_exec_edge: assert property (p_exec_edge)
		else $error("Select rise did not execute the command.");

	property p_apb_answer;
		psel && penable && !pready_r |=> pready_r ##1 !pready_r;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("APB answer timing wrong.");

	property p_wake_b;
		exec && (ctl == CC_WAKE) |=> $stable(dac_b_r) &&
			$stable(in_b_r);
	endproperty
	a_wake_b: assert property (p_wake_b)
		else $error("Wake code altered channel B.");

	property p_sleep_keep;
		sleep_r && $past(sleep_r) |-> $stable(dac_a_r) &&
			$stable(dac_b_r);
	endproperty
	a_sleep_keep: assert property (p_sleep_keep)
		else $error("DAC register moved during sleep.");

	property p_reset_zero;
		!$past(arst_n) |-> dac_a_r == CODE_RST &&
			dac_b_r == CODE_RST && !outputs_hiz;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("Outputs not at zero scale after reset.");

	property p_link_off;
		!link_en_r |=> $stable(shift_r) && $stable(sleep_r) &&
			$stable(in_a_r) && $stable(in_b_r) && $stable(dac_a_r);
	endproperty
	a_link_off: assert property (p_link_off)
		else $error("Link acted while disabled.");

	property p_exec_last;
		exec |=> last_r == $past(shift_r);
	endproperty
	a_exec_last: assert property (p_exec_last)
		else $error("Executed word not recorded.");

	property p_idle_hold;
		!exec |=> $stable(in_a_r) && $stable(in_b_r) &&
			$stable(dac_a_r) && $stable(dac_b_r) && $stable(sleep_r);
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("State changed without a select rise.");

	property p_upd_pair;
		exec && upd |=> dac_a_r == in_a_r && dac_b_r == in_b_r;
	endproperty
	a_upd_pair: assert property (p_upd_pair)
		else $error("DAC registers not updated together.");

	property p_sleep_load_b;
		sleep_r && exec && (ctl == CC_LOAD_B) |=>
			in_b_r == $past(code) && outputs_hiz;
	endproperty
	a_sleep_load_b: assert property (p_sleep_load_b)
		else $error("Load B during sleep misbehaved.");

	property p_ready_pulse;
		pready_r |=> !pready_r;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("Ready stood longer than one cycle.");

	property p_err_ready;
		pslverr_r |-> pready_r;
	endproperty
	a_err_ready: assert property (p_err_ready)
		else $error("Error flag raised without ready.");
endmodule

// ### core/ddc_pkg.sv
/*
 * Shared constants for the dual DAC serial command core: command word
 * layout, control codes, register offsets and reset values.
 * Assumes a 32-bit APB register bus and a 10-bit code per channel.
 */
package ddc_pkg;
	localparam int WORD_W = 16;
	localparam int CTL_W = 4;
	localparam int CODE_W = 10;
	localparam int CTL_LSB = 12;
	localparam int CODE_LSB = 2;
	localparam int PADDR_W = 8;

	localparam logic [3:0] CC_NOP = 4'h0;
	localparam logic [3:0] CC_LOAD_A = 4'h1;
	localparam logic [3:0] CC_LOAD_B = 4'h2;
	localparam logic [3:0] CC_UPDATE = 4'h8;
	localparam logic [3:0] CC_UPD_A = 4'h9;
	localparam logic [3:0] CC_UPD_B = 4'ha;
	localparam logic [3:0] CC_WAKE = 4'hd;
	localparam logic [3:0] CC_SLEEP = 4'he;
	localparam logic [3:0] CC_BOTH = 4'hf;

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_INPUT = 8'h08;
	localparam logic [7:0] OFS_DAC = 8'h0c;
	localparam logic [7:0] OFS_LAST = 8'h10;

	localparam int CTRL_EN_BIT = 0;
	localparam int ST_SLEEP_BIT = 0;
	localparam int ST_CS_BIT = 1;
	localparam int ST_EN_BIT = 2;
	localparam int HI_LSB = 16;

	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [9:0] CODE_RST = 10'h000;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

// ### tb/ddc_host.sv
/*
 * Host model for the three-wire link: shifts 16-bit words MSB first.
 * Assumes the bench clock of 4 ns; the link clock runs in frames, and in stray with select high.
 */
`timescale 1ns/1ps
module ddc_host (
	input wire logic clk,
	output logic chip_select_load,
	output logic serial_shift_clock,
	output logic serial_data_in
);
	initial begin
		chip_select_load = 1'b1;
		serial_shift_clock = 1'b0;
		serial_data_in = 1'b0;
	end
	// Waits 80 ns, half a link clock period of 160 ns.
	task automatic half();
		repeat (20) @(posedge clk);
	endtask
	// Sends one whole command word as a frame.
	task automatic send(input logic [15:0] w);
		@(posedge clk);
		serial_shift_clock <= 1'b0;
		chip_select_load <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			half();
			serial_shift_clock <= 1'b0;
			serial_data_in <= w[i];
			half();
			serial_shift_clock <= 1'b1;
		end
		half();
		serial_shift_clock <= 1'b0;
		serial_data_in <= ~w[0];
		half();
		chip_select_load <= 1'b1;
	endtask
	// Toggles the link clock with select high; nothing may shift.
	task automatic stray(input int n);
		for (int i = 0; i < n; i++) begin
			half();
			serial_data_in <= 1'b1;
			serial_shift_clock <= 1'b1;
			half();
			serial_shift_clock <= 1'b0;
		end
	endtask
endmodule

// ### tb/ddc_core_tb.sv
/*
 * Self-checking bench for the serial command core.
 * Assumes APB answers with pready and the host model drives the link.
 */
`timescale 1ns/1ps
module ddc_core_tb
	import ddc_pkg::*;
;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, cs, sck, sdi, hiz, en;
	logic [9:0] dac_a, dac_b, ia, ib, da, db;
	logic slp;
	logic [15:0] lw = 16'h0000;
	int failures = 0;
	int compares = 0;
	logic [3:0] rsv [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hb, 4'hc};
	always #2 clk = ~clk;
	ddc_core i_ddc_core (.clk(clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chip_select_load(cs),
		.serial_shift_clock(sck), .serial_data_in(sdi),
		.dac_a_out(dac_a), .dac_b_out(dac_b), .outputs_hiz(hiz));
	ddc_host i_ddc_host (.clk(clk), .chip_select_load(cs),
		.serial_shift_clock(sck), .serial_data_in(sdi));
	task automatic give_verdict();
		if (failures == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Sends one command and checks the result against the expected state.
	task automatic cmd(input logic [3:0] c, input logic [9:0] v);
		i_ddc_host.send({c, v, ~v[1:0]});
		if (en) begin
			lw = {c, v, ~v[1:0]};
			case (c)
				4'h1: ia = v;
				4'h2: ib = v;
				4'h8: {da, db, slp} = {ia, ib, 1'b0};
				4'h9: {ia, da, db, slp} = {v, v, ib, 1'b0};
				4'ha: {ib, da, db, slp} = {v, ia, v, 1'b0};
				4'hd: slp = 1'b0;
				4'he: slp = 1'b1;
				4'hf: {ia, ib, da, db, slp} = {v, v, v, v, 1'b0};
				default: slp = slp;
			endcase
		end
		repeat (8) @(posedge clk);
		chk("dac_a_out", {22'h0, da}, {22'h0, dac_a});
		chk("dac_b_out", {22'h0, db}, {22'h0, dac_b});
		chk("outputs_hiz", {31'h0, slp}, {31'h0, hiz});
		apb(1'b0, OFS_INPUT, DATA_ZERO);
		chk("input", {6'h0, ib, 6'h0, ia}, rd);
		apb(1'b0, OFS_DAC, DATA_ZERO);
		chk("dac", {6'h0, db, 6'h0, da}, rd);
		apb(1'b0, OFS_LAST, DATA_ZERO);
		chk("last", {16'h0, lw}, rd);
		apb(1'b0, OFS_STATUS, DATA_ZERO);
		chk("status", {29'h0, en, 1'b1, slp}, rd);
	endtask
	task automatic t_stray();
		i_ddc_host.stray(4);
		chk("stray_a", {22'h0, da}, {22'h0, dac_a});
		chk("stray_b", {22'h0, db}, {22'h0, dac_b});
	endtask
	task automatic t_reset();
		chk("reset_a", 32'h0, {22'h0, dac_a});
		chk("reset_hiz", 32'h0, {31'h0, hiz});
		apb(1'b1, OFS_DAC, 32'hffff_ffff);
		apb(1'b0, OFS_DAC, DATA_ZERO);
		chk("ro_dac", 32'h0, rd);
		apb(1'b0, 8'h14, DATA_ZERO);
		chk("unmapped_err", 32'h1, {31'h0, er});
	endtask
	task automatic t_loads();
		cmd(4'h1, 10'h2a5);
		cmd(4'h2, 10'h15a);
		cmd(4'h8, 10'h3ff);
		cmd(4'h9, 10'h3ff);
		cmd(4'ha, 10'h001);
		cmd(4'hf, 10'h200);
	endtask
	task automatic t_sleep();
		cmd(4'he, 10'h123);
		cmd(4'h1, 10'h0f0);
		cmd(4'h0, 10'h0ff);
		cmd(4'hd, 10'h111);
		cmd(4'he, 10'h000);
		cmd(4'h2, 10'h30c);
		cmd(4'h8, 10'h000);
	endtask
	task automatic t_reserved();
		foreach (rsv[i])
			cmd(rsv[i], 10'h3c3);
	endtask
	task automatic t_disable();
		apb(1'b1, OFS_CTRL, DATA_ZERO);
		apb(1'b0, OFS_STATUS, DATA_ZERO);
		chk("status_en", 32'h0, {31'h0, rd[ST_EN_BIT]});
		en = 1'b0;
		cmd(4'hf, 10'h0aa);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		en = 1'b1;
		cmd(4'h9, 10'h055);
	endtask
	initial begin
		{ia, ib, da, db, slp, en} = {40'h0, 2'b01};
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_loads();
		t_stray();
		t_sleep();
		t_reserved();
		t_disable();
		give_verdict();
	end
	initial begin
		#300000;
		failures++;
		give_verdict();
	end
endmodule
